//--- rtl/timer16_pkg.sv
package timer16_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] OFF_CMP_A = 8'h0C;
	localparam logic [7:0] OFF_CMP_B = 8'h10;
	localparam logic [7:0] OFF_CAPTURE = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_MASK = 8'h1C;
	localparam logic [7:0] OFF_OUT_EN = 8'h20;

	// Control A fields
	localparam int WAVE_LO_POS = 0;
	localparam int MODE_B_LO_POS = 4;
	localparam int MODE_B_HI_POS = 5;
	localparam int MODE_A_LO_POS = 6;
	localparam int MODE_A_HI_POS = 7;
	localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
	// Control B fields
	localparam int WAVE_HI_POS = 3;
	localparam logic [7:0] CTRL_B_WMASK = 8'h18;
	// Status and mask bits
	localparam int ST_OVERFLOW = 0;
	localparam int ST_MATCH_A = 1;
	localparam int ST_MATCH_B = 2;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic [1:0] OUT_EN_RESET = 2'h0;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Counter limits
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;

	// Waveform modes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PC8 = 4'h1;
	localparam logic [3:0] MODE_PC9 = 4'h2;
	localparam logic [3:0] MODE_PC10 = 4'h3;
	localparam logic [3:0] MODE_CTC_CMP = 4'h4;
	localparam logic [3:0] MODE_FAST8 = 4'h5;
	localparam logic [3:0] MODE_FAST9 = 4'h6;
	localparam logic [3:0] MODE_FAST10 = 4'h7;
	localparam logic [3:0] MODE_PFC_CAP = 4'h8;
	localparam logic [3:0] MODE_PFC_CMP = 4'h9;
	localparam logic [3:0] MODE_PC_CAP = 4'hA;
	localparam logic [3:0] MODE_PC_CMP = 4'hB;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] MODE_RESERVED = 4'hD;
	localparam logic [3:0] MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] MODE_FAST_CMP = 4'hF;

	function automatic logic is_dual_slope(input logic [3:0] mode);
		is_dual_slope = mode inside {MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CAP,
			MODE_PFC_CMP, MODE_PC_CAP, MODE_PC_CMP};
	endfunction

	function automatic logic is_fast(input logic [3:0] mode);
		is_fast = mode inside {MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP,
			MODE_FAST_CMP};
	endfunction

	function automatic logic is_direct(input logic [3:0] mode);
		is_direct = mode inside {MODE_NORMAL, MODE_CTC_CMP, MODE_CTC_CAP};
	endfunction

	function automatic logic is_pfc(input logic [3:0] mode);
		is_pfc = mode inside {MODE_PFC_CAP, MODE_PFC_CMP};
	endfunction

	function automatic logic [15:0] top_select(input logic [3:0] mode,
		input logic [15:0] cmp_a, input logic [15:0] capture);
		case (mode)
			MODE_NORMAL: top_select = TOP_MAX;
			MODE_PC8, MODE_FAST8: top_select = TOP_8;
			MODE_PC9, MODE_FAST9: top_select = TOP_9;
			MODE_PC10, MODE_FAST10: top_select = TOP_10;
			MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP: top_select = cmp_a;
			default: top_select = capture;
		endcase
	endfunction

endpackage

//--- rtl/timer16_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer16_core_if;
	logic [3:0] mode;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic [15:0] capture;
	logic [15:0] count;
	logic count_down;
	logic overflow;
	logic reload;

	modport ctr_mp (input mode, input cmp_a, input capture,
		output count, output count_down, output overflow, output reload);
	modport out_mp (input mode, input cmp_a, input cmp_b, input count, input count_down);
	modport top_mp (output mode, output cmp_a, output cmp_b, output capture,
		input count, input count_down, input overflow, input reload);
endinterface
`default_nettype wire

//--- rtl/timer16_counter.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_counter
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Core signals
	timer16_core_if.ctr_mp core
);
	logic [15:0] top_value;
	logic [15:0] next_count;
	logic next_down;
	wire at_top = core.count == top_value;
	wire at_bottom = core.count == BOTTOM;
	wire at_max = core.count == TOP_MAX;
	wire dual = is_dual_slope(core.mode);
	wire held = core.mode == MODE_RESERVED;

	assign top_value = top_select(core.mode, core.cmp_a, core.capture);
	assign core.overflow = is_direct(core.mode) ? at_max :
		dual ? (at_bottom && core.count_down) :
		(is_fast(core.mode) && at_top);
	assign core.reload = held ? 1'b0 : is_direct(core.mode) ? 1'b1 :
		is_pfc(core.mode) ? (at_bottom && core.count_down) : at_top;

	always_comb
	begin
		next_count = core.count;
		next_down = core.count_down;
		if (held)
		begin
			// Undefined mode: freeze rather than invent a sequence
			next_count = core.count;
		end
		else if (dual)
		begin
			if (!core.count_down)
			begin
				if (core.count >= top_value && !at_bottom)
				begin
					next_down = 1'b1;
					next_count = core.count - 16'h0001;
				end
				else if (!at_top)
					next_count = core.count + 16'h0001;
			end
			else if (at_bottom)
			begin
				next_down = 1'b0;
				if (!at_top)
					next_count = core.count + 16'h0001;
			end
			else
				next_count = core.count - 16'h0001;
		end
		else
		begin
			next_down = 1'b0;
			next_count = at_top ? BOTTOM : core.count + 16'h0001;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core.count <= VALUE_RESET;
			core.count_down <= 1'b0;
		end
		else
		begin
			core.count <= next_count;
			core.count_down <= next_down;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_reach_top;
		dual && !core.count_down && at_top && !at_bottom;
	endsequence

	AST_RESERVED_HOLD: assert property (held |=> $stable(core.count))
		else $error("count moved in reserved mode");
	AST_NORMAL_WRAP: assert property ((core.mode == MODE_NORMAL && at_max)
		|-> core.overflow ##1 core.count == BOTTOM)
		else $error("normal mode did not wrap with overflow");
	AST_CTC_CLEAR: assert property ((core.mode == MODE_CTC_CMP && at_top)
		|=> core.count == BOTTOM)
		else $error("clear on compare A did not clear");
	AST_DUAL_TURN: assert property (s_reach_top
		|=> core.count_down && core.count == $past(core.count) - 16'h0001)
		else $error("dual slope did not turn at top");
	AST_PC_OVERFLOW: assert property ((dual && core.overflow)
		|-> at_bottom ##1 !core.count_down)
		else $error("dual slope overflow not at bottom");
	AST_FAST_TOP: assert property ((is_fast(core.mode) && at_top)
		|-> core.overflow && core.reload ##1 core.count == BOTTOM)
		else $error("fast mode top events wrong");
	AST_PFC_UPDATE: assert property ((is_pfc(core.mode) && core.reload)
		|-> at_bottom && core.count_down)
		else $error("frequency correct update not at bottom");
endmodule
`default_nettype wire

//--- rtl/timer16_outputs.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_outputs
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Core signals
	timer16_core_if.out_mp core,
	// Channel controls, index 0 is A
	input wire logic [1:0] out_enable,
	input wire logic [1:0] out_mode_hi,
	input wire logic [1:0] out_mode_lo,
	// Pins
	output logic [1:0] pin_level,
	output logic [1:0] pin_oe
);
	logic [15:0] cmp [2];
	wire dual = is_dual_slope(core.mode);

	assign cmp[0] = core.cmp_a;
	assign cmp[1] = core.cmp_b;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_chan
			wire match = core.count == cmp[i];
			// Channel B has no toggle; its 01 setting stays disconnected
			wire toggle = !out_mode_hi[i] && out_mode_lo[i] && core.mode[3] && (i == 0);
			wire connected = out_enable[i] && dual && (out_mode_hi[i] || toggle);
			wire next_level = !match ? pin_level[i] :
				out_mode_hi[i] ? (core.count_down ^ out_mode_lo[i]) :
				toggle ? !pin_level[i] : pin_level[i];

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pin_level[i] <= 1'b0;
					pin_oe[i] <= 1'b0;
				end
				else
				begin
					pin_level[i] <= connected ? next_level : pin_level[i];
					pin_oe[i] <= connected;
				end
			end

			AST_DISCONNECT: assert property ((!out_enable[i] || !dual ||
				(!out_mode_hi[i] && !(out_mode_lo[i] && core.mode[3]))) |=> !pin_oe[i])
				else $error("compare output driven while disconnected");
			AST_CLEAR_UP: assert property ((connected && match && out_mode_hi[i] &&
				!out_mode_lo[i]) |=> pin_level[i] == $past(core.count_down))
				else $error("mode 10 level wrong after match");
			AST_SET_UP: assert property ((connected && match && out_mode_hi[i] &&
				out_mode_lo[i]) |=> pin_level[i] == !$past(core.count_down))
				else $error("mode 11 level wrong after match");
		end
	endgenerate

	AST_TOGGLE_A: assert property ((g_chan[0].connected && g_chan[0].toggle &&
		g_chan[0].match) |=> pin_level[0] != $past(pin_level[0]))
		else $error("compare output A did not toggle");
	AST_B_NO_TOGGLE: assert property ((!out_mode_hi[1] && out_mode_lo[1])
		|=> !pin_oe[1])
		else $error("compare output B driven in reserved setting");
endmodule
`default_nettype wire

//--- rtl/timer16_waveform_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Compare output pins
	output logic compare_out_a,
	output logic compare_out_a_oe,
	output logic compare_out_b,
	output logic compare_out_b_oe,
	// Interrupt
	output logic irq
);
	timer16_core_if core ();

	logic [7:0] timer16_control_a;
	logic [7:0] timer16_control_b;
	logic [15:0] cmp_a_buf;
	logic [15:0] cmp_b_buf;
	logic [15:0] cmp_a_act;
	logic [15:0] cmp_b_act;
	logic [15:0] capture_value;
	logic [2:0] status;
	logic [2:0] mask;
	logic [1:0] out_enable;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] rd_word;
	logic [1:0] pin_level;
	logic [1:0] pin_oe;

	function automatic logic addr_mapped(input logic [7:0] addr);
		addr_mapped = {addr[7:2], 2'b00} inside {OFF_CTRL_A, OFF_CTRL_B, OFF_COUNT,
			OFF_CMP_A, OFF_CMP_B, OFF_CAPTURE, OFF_STATUS, OFF_MASK, OFF_OUT_EN};
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction

	// Decode of the held write
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire [7:0] wr_off = {aw_addr[7:2], 2'b00};
	wire wr_ctrl_a = do_write && wr_off == OFF_CTRL_A && w_strb[0];
	wire wr_ctrl_b = do_write && wr_off == OFF_CTRL_B && w_strb[0];
	wire wr_cmp_a = do_write && wr_off == OFF_CMP_A;
	wire wr_cmp_b = do_write && wr_off == OFF_CMP_B;
	wire wr_capture = do_write && wr_off == OFF_CAPTURE;
	wire wr_status = do_write && wr_off == OFF_STATUS && w_strb[0];
	wire wr_mask = do_write && wr_off == OFF_MASK && w_strb[0];
	wire wr_out_en = do_write && wr_off == OFF_OUT_EN && w_strb[0];
	wire [7:0] rd_off = {s_axi_araddr[7:2], 2'b00};
	wire rd_take = s_axi_arvalid && s_axi_arready;

	// Events and flag clearing
	wire match_a = core.count == cmp_a_act;
	wire match_b = core.count == cmp_b_act;
	wire [2:0] events = {match_b, match_a, core.overflow};
	wire [2:0] status_clr = wr_status ? w_data[2:0] : FLAGS_RESET;

	assign core.mode = {timer16_control_b[WAVE_HI_POS +: 2],
		timer16_control_a[WAVE_LO_POS +: 2]};
	assign core.cmp_a = cmp_a_act;
	assign core.cmp_b = cmp_b_act;
	assign core.capture = capture_value;

	assign compare_out_a = pin_level[0];
	assign compare_out_b = pin_level[1];
	assign compare_out_a_oe = pin_oe[0];
	assign compare_out_b_oe = pin_oe[1];

	timer16_counter u_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.core(core.ctr_mp)
	);

	timer16_outputs u_outputs (
		.aclk(aclk),
		.aresetn(aresetn),
		.core(core.out_mp),
		.out_enable(out_enable),
		.out_mode_hi({timer16_control_a[MODE_B_HI_POS], timer16_control_a[MODE_A_HI_POS]}),
		.out_mode_lo({timer16_control_a[MODE_B_LO_POS], timer16_control_a[MODE_A_LO_POS]}),
		.pin_level(pin_level),
		.pin_oe(pin_oe)
	);

	always_comb
	begin
		rd_word = 32'h00000000;
		case (rd_off)
			OFF_CTRL_A: rd_word[7:0] = timer16_control_a;
			OFF_CTRL_B: rd_word[7:0] = timer16_control_b;
			OFF_COUNT: rd_word[15:0] = core.count;
			OFF_CMP_A: rd_word[15:0] = cmp_a_buf;
			OFF_CMP_B: rd_word[15:0] = cmp_b_buf;
			OFF_CAPTURE: rd_word[15:0] = capture_value;
			OFF_STATUS: rd_word[2:0] = status;
			OFF_MASK: rd_word[2:0] = mask;
			OFF_OUT_EN: rd_word[1:0] = out_enable;
			default: rd_word = 32'h00000000;
		endcase
	end

	// Write channels are taken independently, in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// One read in flight; data is sampled at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rd_take)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Software registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer16_control_a <= CTRL_RESET;
			timer16_control_b <= CTRL_RESET;
			cmp_a_buf <= VALUE_RESET;
			cmp_b_buf <= VALUE_RESET;
			capture_value <= VALUE_RESET;
			mask <= FLAGS_RESET;
			out_enable <= OUT_EN_RESET;
		end
		else
		begin
			if (wr_ctrl_a)
				timer16_control_a <= w_data[7:0] & CTRL_A_WMASK;
			if (wr_ctrl_b)
				timer16_control_b <= w_data[7:0] & CTRL_B_WMASK;
			if (wr_cmp_a)
				cmp_a_buf <= merge16(cmp_a_buf, w_data, w_strb);
			if (wr_cmp_b)
				cmp_b_buf <= merge16(cmp_b_buf, w_data, w_strb);
			if (wr_capture)
				capture_value <= merge16(capture_value, w_data, w_strb);
			if (wr_mask)
				mask <= w_data[2:0];
			if (wr_out_en)
				out_enable <= w_data[1:0];
		end
	end

	// Active compare copies follow the buffers at the mode's update point
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmp_a_act <= VALUE_RESET;
			cmp_b_act <= VALUE_RESET;
		end
		else if (core.reload)
		begin
			cmp_a_act <= cmp_a_buf;
			cmp_b_act <= cmp_b_buf;
		end
	end

	// Sticky flags: a new event beats a same-cycle clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status <= FLAGS_RESET;
			irq <= 1'b0;
		end
		else
		begin
			status <= (status & ~status_clr) | events;
			irq <= |(status & mask);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_RESERVED_READ: assert property ((rd_take && rd_off == OFF_CTRL_A)
		|=> s_axi_rvalid && s_axi_rdata[3:2] == 2'b00)
		else $error("reserved control bits read nonzero");
	AST_MODE_LOW: assert property (wr_ctrl_a
		|=> core.mode[1:0] == $past(w_data[WAVE_LO_POS +: 2]))
		else $error("low mode bits not taken from control A");
	AST_MODE_HIGH: assert property (wr_ctrl_b
		|=> core.mode[3:2] == $past(w_data[WAVE_HI_POS +: 2]))
		else $error("high mode bits not taken from control B");
	AST_IMMEDIATE_UPDATE: assert property ((is_direct(core.mode) && wr_cmp_a &&
		w_strb[1:0] == 2'b11) |=> ##1 cmp_a_act == $past(w_data[15:0], 2))
		else $error("immediate compare update late");
	AST_HELD_UPDATE: assert property ((!core.reload && !is_direct(core.mode))
		|=> cmp_a_act == $past(cmp_a_act))
		else $error("compare value changed outside update point");
	AST_FLAG_SET: assert property (core.overflow |=> status[ST_OVERFLOW])
		else $error("overflow event lost");
	AST_IRQ_LEVEL: assert property ((status[ST_MATCH_A] && mask[ST_MATCH_A]) |=> irq)
		else $error("unmasked flag did not raise interrupt");
	AST_WRITE_RESP: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready) |=> ##1 s_axi_bvalid)
		else $error("write response not given");
endmodule
`default_nettype wire

//--- dv/pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module pin_load
(
	// Clock
	input wire logic aclk,
	// Pin as driven
	input wire logic level,
	input wire logic oe,
	// Level seen at the load
	output logic wire_lvl
);
	logic last;
	// No pull on the line, so a released pin reads inverted
	assign wire_lvl = oe ? level : ~last;
	always_ff @(posedge aclk)
		last <= level;
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import timer16_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rdv;
	logic pa, pa_oe, pb, pb_oe, irq, a_wire, b_wire;
	logic [1:0] rs;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	int n, n1, n2;

	timer16_waveform_mode_control u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(rready), .compare_out_a(pa), .compare_out_a_oe(pa_oe),
		.compare_out_b(pb), .compare_out_b_oe(pb_oe), .irq(irq));
	pin_load u_load_a (.aclk(aclk), .level(pa), .oe(pa_oe), .wire_lvl(a_wire));
	pin_load u_load_b (.aclk(aclk), .level(pb), .oe(pb_oe), .wire_lvl(b_wire));

	initial
	begin
		forever #10 aclk = ~aclk;
	end

	task automatic end_sim();
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Whole run is dominated by one 16-bit wrap
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awready)
				awvalid <= 1'b0;
			if (s_axi_wready)
				wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				rs = s_axi_bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arready)
				arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				rdv = s_axi_rdata;
				rs = s_axi_rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// Mode bits are split over both control registers
	task automatic set_mode(input logic [3:0] m, input logic [7:0] outs);
		wr(OFF_CTRL_A, {24'h0, outs[7:2], m[1:0]});
		wr(OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
	endtask

	task automatic wait_a(input logic lvl, output int cnt);
		cnt = 0;
		while (a_wire !== lvl && cnt < 1000)
		begin
			@(posedge aclk);
			cnt++;
		end
	endtask

	task automatic t_reset();
		logic [7:0] regs [5] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_STATUS, OFF_MASK, OFF_OUT_EN};
		foreach (regs[i])
		begin
			rd(regs[i]);
			// Count and compares start equal, so both match flags set
			chk("reset_reg", rdv, (regs[i] == OFF_STATUS) ? 32'h6 : 32'h0);
		end
		chk("reset_pins", {pa_oe, pb_oe, irq}, 32'h0);
	endtask

	task automatic t_normal();
		wr(OFF_CMP_A, 32'hFFF0);
		wr(OFF_CMP_B, 32'hFFF0);
		wr(OFF_STATUS, 32'h7);
		rd(OFF_STATUS);
		chk("normal_early", rdv, 32'h0);
		wr(OFF_MASK, 32'h1);
		n = 0;
		while (irq !== 1'b1 && n < 70000)
		begin
			@(posedge aclk);
			n++;
		end
		rd(OFF_STATUS);
		chk("normal_wrap", rdv, 32'h7);
	endtask

	task automatic t_ctrl();
		wr(OFF_CTRL_A, 32'hFF);
		rd(OFF_CTRL_A);
		chk("ctrl_a", rdv, 32'hF3);
		wr(OFF_CTRL_B, 32'hFF);
		rd(OFF_CTRL_B);
		chk("ctrl_b", rdv, 32'h18);
		wr(8'h40, 32'h1);
		chk("bad_wr", rs, RESP_SLVERR);
		rd(8'h40);
		chk("bad_rd", rdv, 32'h0);
		chk("bad_rresp", rs, RESP_SLVERR);
	endtask

	// Fresh reset keeps the count below the small TOP values used next
	task automatic t_ctc();
		wr(OFF_CMP_A, 32'h40);
		wr(OFF_CMP_B, 32'h48);
		wr(OFF_CAPTURE, 32'h50);
		set_mode(MODE_CTC_CMP, 8'h00);
		wr(OFF_STATUS, 32'h7);
		repeat (200) @(posedge aclk);
		rd(OFF_STATUS);
		chk("ctc_cmp", rdv, 32'h2);
		chk("irq_masked", irq, 1'b0);
		wr(OFF_MASK, 32'h2);
		repeat (3) @(posedge aclk);
		chk("irq_on", irq, 1'b1);
		set_mode(MODE_CTC_CAP, 8'h00);
		wr(OFF_STATUS, 32'h7);
		repeat (200) @(posedge aclk);
		rd(OFF_STATUS);
		chk("ctc_cap", rdv, 32'h6);
		wr(OFF_MASK, 32'h0);
		repeat (3) @(posedge aclk);
		chk("irq_off", irq, 1'b0);
	endtask

	task automatic t_sweep();
		logic [3:0] modes [10] = '{4'h8, 4'hA, 4'hE, 4'h1, 4'h5, 4'h6, 4'hD, 4'h9, 4'hB, 4'hF};
		logic dual;
		wr(OFF_CMP_B, 32'h40);
		wr(OFF_OUT_EN, 32'h3);
		foreach (modes[i])
		begin
			dual = modes[i] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
			set_mode(modes[i], 8'hB0);
			wr(OFF_STATUS, 32'h7);
			repeat (600) @(posedge aclk);
			rd(OFF_STATUS);
			chk("overflow", rdv[0], modes[i] != 4'hD);
			chk("pin_oe", {pb_oe, pa_oe}, {2{dual}});
		end
	endtask

	task automatic t_pwm();
		set_mode(MODE_PC8, 8'hB0);
		wait_a(1'b1, n);
		wait_a(1'b0, n);
		wait_a(1'b1, n);
		chk("a_low_len", n >= 381 && n <= 384, 1'b1);
		@(posedge aclk);
		chk("a_b_levels", {b_wire, a_wire}, 2'b01);
	endtask

	task automatic t_toggle();
		set_mode(MODE_PC8, 8'h50);
		repeat (3) @(posedge aclk);
		chk("oe_toggle_off", {pb_oe, pa_oe}, 2'b00);
		wr(OFF_CAPTURE, 32'h100);
		set_mode(MODE_PC_CAP, 8'h50);
		repeat (3) @(posedge aclk);
		chk("oe_toggle_on", {pb_oe, pa_oe}, 2'b01);
		wait_a(!a_wire, n);
		wait_a(!a_wire, n1);
		wait_a(!a_wire, n2);
		chk("toggle_period", n1 + n2 >= 510 && n1 + n2 <= 514, 1'b1);
		wr(OFF_OUT_EN, 32'h0);
		repeat (3) @(posedge aclk);
		chk("oe_disabled", {pb_oe, pa_oe}, 2'b00);
	endtask

	initial
	begin
		do_reset();
		t_reset();
		t_normal();
		t_ctrl();
		do_reset();
		t_ctc();
		t_sweep();
		t_pwm();
		t_toggle();
		end_sim();
	end
endmodule
`default_nettype wire
